/* File: logic/shbp_cfg.svh */
// Constants for the slave host buffer port: bit positions, opcodes, resets
`ifndef SHBP_CFG_SVH
`define SHBP_CFG_SVH
// =====================================================================
// Status register field positions
`define SHBP_ST_OUT_FULL 0
`define SHBP_ST_IN_FULL  1
`define SHBP_ST_UFA      2
`define SHBP_ST_CDF      3
`define SHBP_ST_USR_LO   4
`define SHBP_ST_USR_HI   7
// =====================================================================
// Interface instruction opcodes
`define SHBP_OP_LOAD_HIGH 8'h90
`define SHBP_OP_EN_FLAGS 8'hf5
`define SHBP_OP_EN_DMA   8'he5
// =====================================================================
// Reset values
`define SHBP_STATUS_RST  8'h00
`define SHBP_DATA_RST    8'h00
`define SHBP_PORT2_RST   4'hf
`endif

/* File: logic/shbp_pkg.sv */
// Types shared by the slave host buffer port
`default_nettype none
package shbp_pkg;
	// Host strobe tracker, Gray coded along idle -> active -> idle
	typedef enum logic [1:0] {
		SHBP_IDLE = 2'b00,
		SHBP_RD   = 2'b01,
		SHBP_WR   = 2'b10
	} shbp_strobe_t;
endpackage
`default_nettype wire

/* File: logic/shbp_port.sv */
// Host-facing buffer port with status register, flag pins and DMA handshake
//
// Contract
// - Status is 8 bits: two full flags, a user flag, the command/data flag, user nibble.
// - Upper four status bits are written only by firmware.
// - Opcode 90h copies accumulator bits 7:4 into status 7:4 only.
// - Buffer flags and the command/data flag update on the rising (trailing) strobe edge.
// - Opcode F5h turns bit4 into out-full pin, bit5 into in-full pin.
// - Flags enabled, port2 bit4 written 1: pin follows out-full flag.
// - Flags enabled, port2 bit4 written 0: pin held low.
// - Flags enabled, port2 bit5 written 1: pin shows inverted input-full state.
// - Flags enabled, port2 bit5 written 0: input state removed from pin.
// - Opcode E5h makes bit6 DMA request and bit7 active-low acknowledge.
// - DMA enabled, port2 bit6 written 1 raises the DMA request.
// - Executing the enable-DMA opcode clears the DMA request.
// - Acknowledge with a read or write strobe clears the DMA request.
// - Acknowledge acts as chip select for the data buffers in DMA mode; register select still routes reads to status.
// - Read strobe fetches output buffer or status; write loads input buffer.
`default_nettype none
`include "shbp_cfg.svh"

module shbp_port (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	// Host bus
	input  wire logic       host_cs_n_i,
	input  wire logic       host_rd_n_i,
	input  wire logic       host_wr_n_i,
	input  wire logic       register_select_i,
	input  wire logic [7:0] host_data_i,
	output logic      [7:0] host_data_o,
	output logic            host_data_oe_o,
	// Firmware side
	input  wire logic       fw_op_valid_i,
	input  wire logic [7:0] fw_opcode_i,
	input  wire logic [7:0] fw_acc_i,
	input  wire logic       fw_out_load_i,
	input  wire logic [7:0] fw_out_data_i,
	input  wire logic       fw_in_read_i,
	input  wire logic       fw_flag_a_wr_i,
	input  wire logic       fw_flag_a_i,
	input  wire logic       fw_cdf_wr_i,
	input  wire logic       fw_cdf_i,
	input  wire logic       fw_p2_wr_i,
	input  wire logic [3:0] fw_p2_hi_i,
	output logic      [7:0] fw_in_data_o,
	output logic      [7:0] fw_status_o,
	// Port 2 upper pins
	input  wire logic       port2_bit7_pin_i,
	output logic            port2_bit4_pin_o,
	output logic            port2_bit5_pin_o,
	output logic            port2_bit6_pin_o
);

	// =================================================================
	// State
	shbp_pkg::shbp_strobe_t strobe;
	shbp_pkg::shbp_strobe_t next_strobe;
	logic [7:0] status;
	logic [7:0] next_status;
	logic [7:0] out_buf;
	logic [7:0] next_out_buf;
	logic [7:0] in_buf;
	logic [7:0] next_in_buf;
	logic       sel_latch;
	logic       next_sel_latch;
	logic [3:0] p2_latch;
	logic [3:0] next_p2_latch;
	logic       flags_en;
	logic       next_flags_en;
	logic       dma_en;
	logic       next_dma_en;
	logic       dma_ack_seen;
	logic       next_dma_ack_seen;
	logic [7:0] next_data_o;
	logic       next_data_oe;
	logic [2:0] next_pins;

	// Strobe is qualified by chip select, or by acknowledge in DMA mode
	logic sel;
	logic dma_sel;
	logic rd_act;
	logic wr_act;
	logic op_load;
	logic op_flags;
	logic op_dma;

	// Opcode match, used by every interface instruction
	function automatic logic op_is(input logic [7:0] code);
		return fw_op_valid_i && (fw_opcode_i == code);
	endfunction

	assign op_load  = op_is(`SHBP_OP_LOAD_HIGH);
	assign op_flags = op_is(`SHBP_OP_EN_FLAGS);
	assign op_dma   = op_is(`SHBP_OP_EN_DMA);
	assign dma_sel  = dma_en && !port2_bit7_pin_i;
	assign sel      = !host_cs_n_i || dma_sel;
	assign rd_act   = sel && !host_rd_n_i;
	assign wr_act   = sel && !host_wr_n_i;

	// =================================================================
	// Next-state logic; read data is driven while the strobe is low, other strobe effects land on the trailing edge
	always_comb begin
		next_strobe       = strobe;
		next_status       = status;
		next_out_buf      = out_buf;
		next_in_buf       = in_buf;
		next_sel_latch    = sel_latch;
		next_p2_latch     = p2_latch;
		next_flags_en     = flags_en;
		next_dma_en       = dma_en;
		next_dma_ack_seen = dma_ack_seen;
		next_data_o       = host_data_o;
		next_data_oe      = 1'b0;
		case (strobe)
			shbp_pkg::SHBP_IDLE: begin
				if (rd_act) begin
					next_strobe    = shbp_pkg::SHBP_RD;
					next_sel_latch = register_select_i;
					next_dma_ack_seen = dma_sel;
				end else if (wr_act) begin
					next_strobe    = shbp_pkg::SHBP_WR;
					next_sel_latch = register_select_i;
					next_dma_ack_seen = dma_sel;
				end
			end
			shbp_pkg::SHBP_RD: begin
				next_data_oe = 1'b1;
				next_data_o  = sel_latch ? status : out_buf;
				if (host_rd_n_i) begin
					next_strobe = shbp_pkg::SHBP_IDLE;
					next_data_oe = 1'b0;
					if (!sel_latch)
						next_status[`SHBP_ST_OUT_FULL] = 1'b0;
				end
			end
			shbp_pkg::SHBP_WR: begin
				// Data is taken at the trailing edge, as the bus holds it
				if (host_wr_n_i) begin
					next_strobe = shbp_pkg::SHBP_IDLE;
					next_in_buf = host_data_i;
					next_status[`SHBP_ST_IN_FULL] = 1'b1;
					next_status[`SHBP_ST_CDF] = sel_latch;
				end
			end
			default: next_strobe = shbp_pkg::SHBP_IDLE;
		endcase
		if (strobe != shbp_pkg::SHBP_IDLE && dma_ack_seen &&
				(host_rd_n_i && host_wr_n_i))
			next_p2_latch[2] = 1'b0;
		// Firmware side; a buffer-full set always wins over a clear in the same cycle,
		// so a fresh load is never lost behind a host read that just ended
		if (fw_out_load_i) begin
			next_out_buf = fw_out_data_i;
			next_status[`SHBP_ST_OUT_FULL] = 1'b1;
		end
		if (fw_in_read_i &&
				!(strobe == shbp_pkg::SHBP_WR && host_wr_n_i))
			next_status[`SHBP_ST_IN_FULL] = 1'b0;
		if (fw_flag_a_wr_i)
			next_status[`SHBP_ST_UFA] = fw_flag_a_i;
		if (fw_cdf_wr_i && !(strobe == shbp_pkg::SHBP_WR && host_wr_n_i))
			next_status[`SHBP_ST_CDF] = fw_cdf_i;
		if (op_load)
			next_status[`SHBP_ST_USR_HI:`SHBP_ST_USR_LO] = fw_acc_i[7:4];
		if (fw_p2_wr_i)
			next_p2_latch = fw_p2_hi_i;
		if (op_flags)
			next_flags_en = 1'b1;
		if (op_dma) begin
			next_dma_en      = 1'b1;
			next_p2_latch[2] = 1'b0;
		end
		// Pin drive: out-full flag pin
		next_pins[0] = flags_en ? (p2_latch[0] & status[`SHBP_ST_OUT_FULL])
			: p2_latch[0];
		// in-full on second pin; shown inverted as readiness
		next_pins[1] = flags_en ? (p2_latch[1] & !status[`SHBP_ST_IN_FULL])
			: p2_latch[1];
		next_pins[2] = p2_latch[2];
	end

	// =================================================================
	// Registers
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strobe           <= shbp_pkg::SHBP_IDLE;
			status           <= `SHBP_STATUS_RST;
			out_buf          <= `SHBP_DATA_RST;
			in_buf           <= `SHBP_DATA_RST;
			sel_latch        <= 1'b0;
			p2_latch         <= `SHBP_PORT2_RST;
			flags_en         <= 1'b0;
			dma_en           <= 1'b0;
			dma_ack_seen     <= 1'b0;
			host_data_o      <= `SHBP_DATA_RST;
			host_data_oe_o   <= 1'b0;
			fw_in_data_o     <= `SHBP_DATA_RST;
			fw_status_o      <= `SHBP_STATUS_RST;
			port2_bit4_pin_o <= 1'b1;
			port2_bit5_pin_o <= 1'b1;
			port2_bit6_pin_o <= 1'b1;
		end else begin
			strobe           <= next_strobe;
			status           <= next_status;
			out_buf          <= next_out_buf;
			in_buf           <= next_in_buf;
			sel_latch        <= next_sel_latch;
			p2_latch         <= next_p2_latch;
			flags_en         <= next_flags_en;
			dma_en           <= next_dma_en;
			dma_ack_seen     <= next_dma_ack_seen;
			host_data_o      <= next_data_o;
			host_data_oe_o   <= next_data_oe;
			fw_in_data_o     <= next_in_buf;
			fw_status_o      <= next_status;
			port2_bit4_pin_o <= next_pins[0];
			port2_bit5_pin_o <= next_pins[1];
			port2_bit6_pin_o <= next_pins[2];
		end
	end

endmodule
`default_nettype wire

/* File: test/shbp_port_assertions.sv */
// Checker for host port timing and status rules
`default_nettype none
`include "shbp_cfg.svh"
module shbp_port_assertions (
	input wire logic       mclk_i, nrst_i, host_cs_n_i, host_rd_n_i,
	input wire logic       host_wr_n_i, register_select_i, fw_op_valid_i,
	input wire logic       host_data_oe_o, port2_bit7_pin_i,
	input wire logic       port2_bit6_pin_o,
	input wire logic [7:0] fw_opcode_i, fw_acc_i, fw_status_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Steps
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	sequence rd_go; $fell(host_rd_n_i) && !host_cs_n_i; endsequence
	// Acknowledged strobe end; only DMA traffic drives the ack low
	sequence ack_end;
		!port2_bit7_pin_i && ($rose(host_rd_n_i) || $rose(host_wr_n_i));
	endsequence
	property nibble_load;
		logic [3:0] v;
		(fw_op_valid_i && fw_opcode_i == `SHBP_OP_LOAD_HIGH,
			v = fw_acc_i[7:4]) |-> ##2 fw_status_o[7:4] == v;
	endproperty
	a_rd_answer: assert property (
		rd_go |-> ##2 host_data_oe_o) else $error("read not answered");
	a_oe_drop: assert property (
		$rose(host_rd_n_i) |=> !host_data_oe_o) else $error("bus held");
	a_obf_clear: assert property (
		$rose(host_rd_n_i) && host_data_oe_o && !register_select_i
		|-> ##2 !fw_status_o[0]) else $error("output full stuck");
	a_ibf_set: assert property (
		$rose(host_wr_n_i) |-> ##2 fw_status_o[1] &&
		fw_status_o[3] == $past(register_select_i, 2))
		else $error("write flags wrong");
	a_user_nibble_load: assert property (nibble_load)
		else $error("status nibble wrong");
	// firmware only; the load edge is one sample before the change
	a_usr_only: assert property (
		$changed(fw_status_o[7:4]) |-> $past(fw_op_valid_i) &&
		$past(fw_opcode_i) == `SHBP_OP_LOAD_HIGH)
		else $error("user bits moved");
	a_dma_clear: assert property (
		ack_end |-> ##2 !port2_bit6_pin_o) else $error("request held");
	a_dma_enable: assert property (
		fw_op_valid_i && fw_opcode_i == `SHBP_OP_EN_DMA
		|-> ##2 !port2_bit6_pin_o) else $error("request after enable");
endmodule
bind shbp_port shbp_port_assertions i_shbp_port_assertions (.mclk_i,
	.nrst_i, .host_cs_n_i, .host_rd_n_i, .host_wr_n_i, .register_select_i,
	.fw_op_valid_i, .host_data_oe_o, .port2_bit7_pin_i, .port2_bit6_pin_o,
	.fw_opcode_i, .fw_acc_i, .fw_status_o);
`default_nettype wire

/* File: test/shbp_host.sv */
// Host bus master model for the buffer port
`default_nettype none
module shbp_host (
	input  wire logic       clk_i, oe_i,
	output logic            cs_n_o, rd_n_o, wr_n_o, sel_o, ack_n_o,
	output logic      [7:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Set when a read is never answered within its bound
	logic late = 1'b0;
	initial {cs_n_o, rd_n_o, wr_n_o, sel_o, ack_n_o, data_o} = 13'h1d00;
	// ==========
	// Transfer: w picks write, k the DMA path
	task automatic xfer(input logic w, s, k, input logic [7:0] v);
		int n;
		n = 0;
		@(negedge clk_i);
		{cs_n_o, ack_n_o, sel_o, data_o} = {k, !k, s, v};
		if (w) wr_n_o = 0;
		else rd_n_o = 0;
		// Sampled on the falling edge, where the answer has settled
		while (!w && !oe_i && n < 8) begin
			@(negedge clk_i);
			n++;
		end
		if (!w && !oe_i)
			late = 1'b1;
		repeat (2) @(negedge clk_i);
		{rd_n_o, wr_n_o} = 2'b11;
		@(negedge clk_i);
		// Freed lines invert so stale data never matches
		{cs_n_o, ack_n_o, data_o} = {2'b11, ~v};
	endtask
endmodule
`default_nettype wire

/* File: test/test_slave_host_buffer_port.sv */
// Self-checking bench for the slave host buffer port
`default_nettype none
`include "shbp_cfg.svh"
module test_slave_host_buffer_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk_i = 0, nrst_i = 0, oq = 0;
	logic       host_cs_n_i, host_rd_n_i, host_wr_n_i, register_select_i;
	logic       port2_bit7_pin_i, host_data_oe_o;
	logic       port2_bit4_pin_o, port2_bit5_pin_o, port2_bit6_pin_o;
	logic [4:0] k = 0;
	logic [3:0] p2 = 0;
	logic [7:0] host_data_i, host_data_o, fw_in_data_o, fw_status_o;
	logic [7:0] op = 0, acc = 0, v = 0, w, st;
	logic [7:0] q[$];
	int         miscompares = 0, comparisons = 0;
	always #5 mclk_i = ~mclk_i;
	shbp_port i_shbp_port (.mclk_i, .nrst_i, .host_cs_n_i, .host_rd_n_i,
		.host_wr_n_i, .register_select_i, .host_data_i, .host_data_o,
		.host_data_oe_o, .fw_op_valid_i(k[4]), .fw_opcode_i(op),
		.fw_acc_i(acc), .fw_out_load_i(k[3]), .fw_out_data_i(v),
		.fw_in_read_i(k[2]), .fw_flag_a_wr_i(k[1]), .fw_flag_a_i(1'b1),
		.fw_cdf_wr_i(1'b0), .fw_cdf_i(1'b0), .fw_p2_wr_i(k[0]),
		.fw_p2_hi_i(p2), .fw_in_data_o, .fw_status_o, .port2_bit7_pin_i,
		.port2_bit4_pin_o, .port2_bit5_pin_o, .port2_bit6_pin_o);
	shbp_host i_shbp_host (.clk_i(mclk_i), .oe_i(host_data_oe_o),
		.cs_n_o(host_cs_n_i), .rd_n_o(host_rd_n_i), .wr_n_o(host_wr_n_i),
		.sel_o(register_select_i), .ack_n_o(port2_bit7_pin_i),
		.data_o(host_data_i));
	// ==========
	// Tasks
	task automatic chk(input logic [7:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pins(input logic [2:0] e);
		chk({port2_bit6_pin_o, port2_bit5_pin_o, port2_bit4_pin_o}, e);
	endtask
	// One firmware strobe, then room for status and pins to land
	task automatic fw(input logic [4:0] s);
		k = s;
		@(negedge mclk_i);
		k = 0;
		repeat (3) @(negedge mclk_i);
	endtask
	task automatic stop_test;
		$display("compared %0d failed %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watcher pops the oldest expected byte as read data appears
	always @(negedge mclk_i) begin
		if (host_data_oe_o && !oq)
			chk(host_data_o, q.pop_front());
		oq = host_data_oe_o;
	end
	initial begin
		repeat (5000) @(posedge mclk_i);
		miscompares++;
		stop_test();
	end
	initial begin
		void'($urandom(88));
		repeat (16) @(negedge mclk_i);
		chk(fw_status_o, 8'h00);
		pins(3'h7);
		nrst_i = 1;
		for (int s = 0; s < 2; s++) begin
			w = 8'($urandom);
			i_shbp_host.xfer(1, s[0], 0, w);
			repeat (3) @(negedge mclk_i);
			chk(fw_in_data_o, w);
			chk(fw_status_o, {4'h0, s[0], 3'h2});
			fw(5'h04);
			chk(fw_status_o, {4'h0, s[0], 3'h0});
		end
		$display("write test done");
		acc = 8'($urandom);
		op = `SHBP_OP_LOAD_HIGH;
		fw(5'h12);
		st = {acc[7:4], 4'hc};
		chk(fw_status_o, st);
		v = 8'($urandom);
		fw(5'h08);
		q.push_back(st | 8'h01);
		i_shbp_host.xfer(0, 1, 0, 0);
		q.push_back(v);
		i_shbp_host.xfer(0, 0, 0, 0);
		repeat (3) @(negedge mclk_i);
		chk(fw_status_o, st);
		$display("read test done");
		op = `SHBP_OP_EN_FLAGS;
		fw(5'h10);
		p2 = 4'hf;
		fw(5'h01);
		pins(3'h6);
		fw(5'h08);
		pins(3'h7);
		i_shbp_host.xfer(1, 0, 0, 8'($urandom));
		repeat (3) @(negedge mclk_i);
		pins(3'h5);
		p2 = 4'hc;
		fw(5'h01);
		pins(3'h4);
		fw(5'h04);
		pins(3'h4);
		$display("flag pin test done");
		op = `SHBP_OP_EN_DMA;
		fw(5'h10);
		pins(3'h0);
		p2 = 4'h4;
		fw(5'h01);
		pins(3'h4);
		q.push_back(v);
		i_shbp_host.xfer(0, 0, 1, 0);
		repeat (3) @(negedge mclk_i);
		pins(3'h0);
		fw(5'h01);
		pins(3'h4);
		w = 8'($urandom);
		i_shbp_host.xfer(1, 1, 1, w);
		repeat (3) @(negedge mclk_i);
		chk(fw_in_data_o, w);
		pins(3'h0);
		chk(8'(q.size()), 8'h00);
		chk(8'(i_shbp_host.late), 8'h00);
		$display("dma test done");
		stop_test();
	end
endmodule
`default_nettype wire
